// file: src/tvae_pkg.sv
// constants, types and register map of the total apparent energy accumulator
package tvae_pkg;
    localparam int RMS_W = 24;
    localparam int GAIN_W = 12;
    localparam int GAIN_FRAC = 12;
    localparam int TERM_W = 52;
    localparam int SUM_W = TERM_W + 2;
    localparam int ACC_W = 49;
    localparam int WIN_W = 24;
    localparam int DIV_W = 8;
    localparam int NPH = 3;
    localparam int UPDATE_CLKS = 12;
    localparam int POWER_SHIFT = 24;
    localparam int MODE_LSB = 6;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 3;
    localparam logic [7:0] ADR_MODE = 8'h00;
    localparam logic [7:0] ADR_APPARENT_POWER_GAIN = 8'h04;
    localparam logic [7:0] ADR_VOLTAGE_CHANNEL_GAIN = 8'h10;
    localparam logic [7:0] ADR_DIV = 8'h1C;
    localparam logic [7:0] ADR_WIN = 8'h20;
    localparam logic [7:0] ADR_RCLR = 8'h24;
    localparam logic [7:0] ADR_STAT = 8'h28;
    localparam logic [7:0] ADR_IEN = 8'h2C;
    localparam logic [7:0] REG_STRIDE = 8'h04;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [2:0] SEL_RST = 3'h7;
    localparam logic [11:0] GAIN_RST = 12'h000;
    localparam logic [7:0] DIV_RST = 8'h00;

    typedef enum logic [1:0] {
        TVAE_M_STAR,
        TVAE_M_AVG,
        TVAE_M_DELTA,
        TVAE_M_SPARE
    } tvae_mode_type;

    typedef struct packed {
        logic [RMS_W-1:0] va;
        logic [RMS_W-1:0] vb;
        logic [RMS_W-1:0] vc;
        logic [RMS_W-1:0] ia;
        logic [RMS_W-1:0] ib;
        logic [RMS_W-1:0] ic;
    } tvae_rms_type;
endpackage : tvae_pkg

// file: src/tvae_term.sv
// one scaled apparent power term: voltage gain, product, power gain
`timescale 1ns/1ps
module tvae_term (
    input wire logic [tvae_pkg::RMS_W-1:0] v,
    input wire logic [tvae_pkg::RMS_W-1:0] i,
    input wire logic signed [tvae_pkg::GAIN_W-1:0] voltage_channel_gain,
    input wire logic signed [tvae_pkg::GAIN_W-1:0] apparent_power_gain,
    input wire logic en,
    output logic signed [tvae_pkg::TERM_W-1:0] term
);
    localparam int VW = tvae_pkg::RMS_W + 2;
    localparam int VGW = VW + tvae_pkg::GAIN_W;
    localparam int PW = VW + tvae_pkg::RMS_W + 1;
    localparam int PGW = PW + tvae_pkg::GAIN_W;
    localparam int F = tvae_pkg::GAIN_FRAC;
    logic signed [VW-1:0] v_s;
    logic signed [VGW-1:0] v_g;
    logic signed [VW-1:0] v_c;
    logic signed [tvae_pkg::RMS_W:0] i_s;
    logic signed [PW-1:0] p;
    logic signed [PGW-1:0] p_g;
    logic signed [tvae_pkg::TERM_W-1:0] scaled;

    // voltage gain scales by one plus gain/4096 here, same form as the power gain
    assign v_s = signed'({2'b00, v});
    assign v_g = v_s * voltage_channel_gain;
    assign v_c = v_s + signed'(v_g[F+VW-1:F]);
    assign i_s = signed'({1'b0, i});
    assign p = v_c * i_s;
    assign p_g = p * apparent_power_gain;
    assign scaled = signed'({p[PW-1], p}) + signed'({p_g[PGW-1], p_g[PGW-1:F]});
    assign term = en ? scaled : '0;
endmodule : tvae_term

// file: src/tvae_div.sv
// sequential signed-by-unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module tvae_div #(
    parameter int N = 49,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic abort,
    input wire logic start,
    input wire logic signed [N-1:0] dividend,
    input wire logic [D-1:0] divisor,
    output logic busy,
    output logic done,
    output logic signed [N-1:0] quotient
);
    localparam int CW = $clog2(N + 1);
    logic [N-1:0] q_r;
    logic [D:0] rem_r;
    logic [D-1:0] dsr_r;
    logic neg_r;
    logic [CW-1:0] cnt_r;
    logic [D:0] rem_t;

    assign rem_t = {rem_r[D-1:0], q_r[N-1]};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= '0;
            rem_r <= '0;
            dsr_r <= '0;
            neg_r <= 1'b0;
            cnt_r <= '0;
            busy <= 1'b0;
        end else if (abort) begin
            busy <= 1'b0;
            cnt_r <= '0;
        end else if (start && !busy) begin
            neg_r <= dividend[N-1];
            q_r <= dividend[N-1] ? N'(-dividend) : N'(dividend);
            dsr_r <= (divisor == '0) ? D'(1) : divisor;
            rem_r <= '0;
            cnt_r <= CW'(N);
            busy <= 1'b1;
        end else if (busy) begin
            // one idle step at count zero so completion is seen with a finished quotient
            if (cnt_r == '0) begin
                busy <= 1'b0;
            end else if (rem_t >= {1'b0, dsr_r}) begin
                rem_r <= rem_t - {1'b0, dsr_r};
                q_r <= {q_r[N-2:0], 1'b1};
                cnt_r <= cnt_r - CW'(1);
            end else begin
                rem_r <= rem_t;
                q_r <= {q_r[N-2:0], 1'b0};
                cnt_r <= cnt_r - CW'(1);
            end
        end
    end

    // result is published only on completion so a reader never sees a half-built value
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            quotient <= '0;
            done <= 1'b0;
        end else begin
            done <= busy && !abort && (cnt_r == '0);
            if (busy && !abort && cnt_r == '0)
                quotient <= neg_r ? signed'(N'(-q_r)) : signed'(q_r);
        end
    end
endmodule : tvae_div

// file: src/tvae_top.sv
// total apparent energy accumulator with classic wishbone register slave
`timescale 1ns/1ps
module tvae_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire tvae_pkg::tvae_rms_type rms,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_n
);
    localparam int CNT_W = $clog2(tvae_pkg::UPDATE_CLKS);
    localparam int GW = tvae_pkg::GAIN_W;
    localparam int AW = tvae_pkg::ACC_W;
    localparam int WW = tvae_pkg::WIN_W;
    localparam int SW = tvae_pkg::SEL_W;

    logic [1:0] mode_r;
    logic [SW-1:0] sel_r;
    logic signed [GW-1:0] apparent_power_gain_r [tvae_pkg::NPH];
    logic signed [GW-1:0] voltage_channel_gain_r [tvae_pkg::NPH];
    logic [tvae_pkg::DIV_W-1:0] div_r;
    logic ien_r;
    logic stat_r;
    logic half_prev_r;
    logic [CNT_W-1:0] cnt_r;
    logic signed [tvae_pkg::SUM_W-1:0] total_r;
    logic signed [AW-1:0] acc_r;
    logic [WW-1:0] win_r;
    logic [31:0] rd_nxt;
    logic accept;
    logic wr;
    logic rd_clr;
    logic tick;
    logic half_now;
    logic half_evt;
    tvae_pkg::tvae_mode_type mode_e;
    logic [tvae_pkg::RMS_W-1:0] v_sel [tvae_pkg::NPH];
    logic [tvae_pkg::RMS_W-1:0] i_sel [tvae_pkg::NPH];
    logic [tvae_pkg::RMS_W:0] va_vc;
    logic signed [tvae_pkg::TERM_W-1:0] term [tvae_pkg::NPH];
    logic signed [tvae_pkg::SUM_W-1:0] pwr_shift;
    logic signed [AW-1:0] pwr_step;
    logic div_busy;
    logic div_done;
    logic signed [AW-1:0] quot;

    function automatic logic [31:0] tvae_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b])
                r[8*b +: 8] = wd[8*b +: 8];
        end
        return r;
    endfunction : tvae_merge

    // one-cycle answer; ack drops in the cycle after it was given
    assign accept = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = accept && wb_we_i;
    assign rd_clr = accept && !wb_we_i && (wb_adr_i == tvae_pkg::ADR_RCLR);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= accept;
            if (accept && !wb_we_i)
                wb_dat_o <= rd_nxt;
        end
    end

    // mode register: combination mode in bits 7:6, term enables in bits 2:0
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= tvae_pkg::MODE_RST;
            sel_r <= tvae_pkg::SEL_RST;
        end else if (wr && wb_adr_i == tvae_pkg::ADR_MODE) begin
            mode_r <= 2'(tvae_merge({24'h0, mode_r, 3'h0, sel_r}, wb_dat_i, wb_sel_i) >> tvae_pkg::MODE_LSB);
            sel_r <= SW'(tvae_merge({24'h0, mode_r, 3'h0, sel_r}, wb_dat_i, wb_sel_i) >> tvae_pkg::SEL_LSB);
        end
    end

    // per-phase gain registers, signed 12 bits in the low bits of a word
    for (genvar k = 0; k < tvae_pkg::NPH; k++) begin : g_gain
        localparam logic [7:0] A_VA = tvae_pkg::ADR_APPARENT_POWER_GAIN + 8'(k) * tvae_pkg::REG_STRIDE;
        localparam logic [7:0] A_V = tvae_pkg::ADR_VOLTAGE_CHANNEL_GAIN + 8'(k) * tvae_pkg::REG_STRIDE;
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                apparent_power_gain_r[k] <= tvae_pkg::GAIN_RST;
                voltage_channel_gain_r[k] <= tvae_pkg::GAIN_RST;
            end else if (wr && wb_adr_i == A_VA) begin
                apparent_power_gain_r[k] <= GW'(tvae_merge(32'(unsigned'(apparent_power_gain_r[k])), wb_dat_i, wb_sel_i));
            end else if (wr && wb_adr_i == A_V) begin
                voltage_channel_gain_r[k] <= GW'(tvae_merge(32'(unsigned'(voltage_channel_gain_r[k])), wb_dat_i, wb_sel_i));
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_r <= tvae_pkg::DIV_RST;
            ien_r <= 1'b0;
        end else begin
            if (wr && wb_adr_i == tvae_pkg::ADR_DIV)
                div_r <= tvae_pkg::DIV_W'(tvae_merge({24'h0, div_r}, wb_dat_i, wb_sel_i));
            if (wr && wb_adr_i == tvae_pkg::ADR_IEN && wb_sel_i[0])
                ien_r <= wb_dat_i[0];
        end
    end

    // read mux; unmapped words and reserved bits read as zero
    always_comb begin
        rd_nxt = '0;
        unique case (wb_adr_i)
            tvae_pkg::ADR_MODE: rd_nxt = {24'h0, mode_r, 3'h0, sel_r};
            tvae_pkg::ADR_DIV: rd_nxt = {24'h0, div_r};
            tvae_pkg::ADR_WIN: rd_nxt = {8'h00, win_r};
            tvae_pkg::ADR_RCLR: rd_nxt = {8'h00, win_r};
            tvae_pkg::ADR_STAT: rd_nxt = {31'h0, stat_r};
            tvae_pkg::ADR_IEN: rd_nxt = {31'h0, ien_r};
            default: rd_nxt = '0;
        endcase
        for (int k = 0; k < tvae_pkg::NPH; k++) begin
            if (wb_adr_i == tvae_pkg::ADR_APPARENT_POWER_GAIN + 8'(k) * tvae_pkg::REG_STRIDE)
                rd_nxt = 32'(unsigned'(apparent_power_gain_r[k]));
            if (wb_adr_i == tvae_pkg::ADR_VOLTAGE_CHANNEL_GAIN + 8'(k) * tvae_pkg::REG_STRIDE)
                rd_nxt = 32'(unsigned'(voltage_channel_gain_r[k]));
        end
    end

    // term operand selection by combination mode; spare code falls back to mode 0
    assign mode_e = tvae_pkg::tvae_mode_type'(mode_r);
    assign va_vc = {1'b0, rms.va} + {1'b0, rms.vc};

    always_comb begin
        v_sel[0] = rms.va;
        v_sel[2] = rms.vc;
        i_sel[0] = rms.ia;
        i_sel[1] = rms.ib;
        i_sel[2] = rms.ic;
        unique case (mode_e)
            tvae_pkg::TVAE_M_AVG: v_sel[1] = va_vc[tvae_pkg::RMS_W:1];
            tvae_pkg::TVAE_M_DELTA: v_sel[1] = rms.va;
            tvae_pkg::TVAE_M_STAR,
            tvae_pkg::TVAE_M_SPARE: v_sel[1] = rms.vb;
        endcase
    end

    for (genvar k = 0; k < tvae_pkg::NPH; k++) begin : g_term
        tvae_term u_term (
            .v(v_sel[k]),
            .i(i_sel[k]),
            .voltage_channel_gain(voltage_channel_gain_r[k]),
            .apparent_power_gain(apparent_power_gain_r[k]),
            .en(sel_r[k]),
            .term(term[k])
        );
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            total_r <= '0;
        else
            total_r <= signed'({{2{term[0][tvae_pkg::TERM_W-1]}}, term[0]})
                + signed'({{2{term[1][tvae_pkg::TERM_W-1]}}, term[1]})
                + signed'({{2{term[2][tvae_pkg::TERM_W-1]}}, term[2]});
    end

    // update strobe every 12 clocks
    assign tick = (cnt_r == CNT_W'(tvae_pkg::UPDATE_CLKS - 1));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            cnt_r <= '0;
        else
            cnt_r <= tick ? '0 : cnt_r + CNT_W'(1);
    end

    // power is brought to accumulator scale; the wide sum would swamp 49 bits
    assign pwr_shift = total_r >>> tvae_pkg::POWER_SHIFT;
    assign pwr_step = pwr_shift[AW-1:0];

    // a read-clear drops any addition landing in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            acc_r <= '0;
        else if (rd_clr)
            acc_r <= '0;
        else if (tick)
            acc_r <= acc_r + pwr_step;
    end

    tvae_div #(
        .N(AW),
        .D(tvae_pkg::DIV_W)
    ) u_div (
        .clk(clk),
        .arst_n(arst_n),
        .abort(rd_clr),
        .start(!div_busy),
        .dividend(acc_r),
        .divisor(div_r),
        .busy(div_busy),
        .done(div_done),
        .quotient(quot)
    );

    // window is the top of the divided value, so wrap to 800000h is natural
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            win_r <= '0;
        else if (rd_clr)
            win_r <= '0;
        else if (div_done)
            win_r <= quot[AW-1:AW-WW];
    end

    // half scale: at or above 400000h when positive, magnitude beyond 400000h when negative
    assign half_now = win_r[WW-1] ^ win_r[WW-2];
    assign half_evt = half_now && !half_prev_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            half_prev_r <= 1'b0;
            stat_r <= 1'b0;
        end else begin
            half_prev_r <= half_now;
            if (half_evt)
                stat_r <= 1'b1;
            else if (wr && wb_adr_i == tvae_pkg::ADR_STAT && wb_sel_i[0] && wb_dat_i[0])
                stat_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            irq_n <= 1'b1;
        else
            irq_n <= !(stat_r && ien_r);
    end
endmodule : tvae_top

// file: dv/tvae_chk.sv
// checker on the register bus and interrupt ports of the accumulator
`timescale 1ns/1ps
module tvae_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_n
);
    logic take;
    logic rd_ack;
    logic [7:0] adr_r;
    logic we_r;
    logic [1:0] mode_r;
    logic [2:0] sel_r;
    logic [7:0] div_r;
    logic ien_r;
    logic [7:0] clr_age_r;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_ack = wb_ack_o && !we_r;
    // resets as a write so no read check fires before the first access
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            adr_r <= 8'h00;
            we_r <= 1'b1;
        end else if (take) begin
            adr_r <= wb_adr_i;
            we_r <= wb_we_i;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= tvae_pkg::MODE_RST;
            sel_r <= tvae_pkg::SEL_RST;
            div_r <= tvae_pkg::DIV_RST;
            ien_r <= 1'b0;
        end else if (take && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == tvae_pkg::ADR_MODE) begin
                mode_r <= wb_dat_i[7:6];
                sel_r <= wb_dat_i[2:0];
            end
            if (wb_adr_i == tvae_pkg::ADR_DIV) div_r <= wb_dat_i[7:0];
            if (wb_adr_i == tvae_pkg::ADR_IEN) ien_r <= wb_dat_i[0];
        end
    end
    // saturates so an old clear never wraps back into range
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) clr_age_r <= 8'hFF;
        else if (take && !wb_we_i && wb_adr_i == tvae_pkg::ADR_RCLR) clr_age_r <= 8'h00;
        else if (clr_age_r != 8'hFF) clr_age_r <= clr_age_r + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_ack_next;
        take |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_mode_read;
        rd_ack && adr_r == tvae_pkg::ADR_MODE |-> wb_dat_o[31:6] == {24'h000000, mode_r};
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode field readback wrong");
    property p_sel_read;
        rd_ack && adr_r == tvae_pkg::ADR_MODE |-> wb_dat_o[5:0] == {3'h0, sel_r};
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("enable bits readback wrong");
    property p_div_read;
        rd_ack && adr_r == tvae_pkg::ADR_DIV |-> wb_dat_o == {24'h000000, div_r};
    endproperty
    a_div_read: assert property (p_div_read) else $error("divider readback wrong");
    property p_win_width;
        rd_ack && (adr_r == tvae_pkg::ADR_WIN || adr_r == tvae_pkg::ADR_RCLR) |-> wb_dat_o[31:24] == 8'h00;
    endproperty
    a_win_width: assert property (p_win_width) else $error("energy wider than 24 bits");
    property p_clr_zero;
        rd_ack && adr_r == tvae_pkg::ADR_WIN && clr_age_r < 8'h28 |-> wb_dat_o == 32'h00000000;
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("energy not zero after clear");
    property p_irq_mask;
        !ien_r && $stable(ien_r) |-> irq_n;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt while disabled");
    property p_unmapped;
        rd_ack && adr_r > tvae_pkg::ADR_IEN |-> wb_dat_o == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : tvae_chk
bind tvae_top tvae_chk u_chk (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_n);

// file: dv/tvae_top_tb.sv
// self-checking bench: register access and timed accumulation runs
`timescale 1ns/1ps
module tvae_top_tb;
    logic clk;
    logic arst_n;
    tvae_pkg::tvae_rms_type rms;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_n;
    logic [31:0] exp_q[$];
    int err_total;
    int check_count;
    logic [23:0] v[3];
    logic [23:0] c[3];
    logic signed [11:0] vg[3];
    logic signed [11:0] pg[3];
    tvae_top u_dut (.clk, .arst_n, .rms, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_n);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected read at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // read answers are paired with the oldest expectation
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) chk(exp_q.pop_front(), wb_dat_o);
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++) @(posedge clk);
        if (n == 50) begin
            err_total++;
            $display("unexpected hang at %0t: no ack", $time);
            conclude();
        end else begin
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge clk);
        end
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h00000000);
    endtask : rd
    // exact only because low rms bits are zero, so no gain step rounds
    function automatic logic [23:0] model(input logic [1:0] m, input logic [2:0] en, input logic [7:0] d,
        input int k);
        longint s;
        longint vv;
        longint q;
        s = 0;
        for (int p = 0; p < 3; p++) begin
            vv = (p != 1) ? v[p] : (m == 2'h1) ? (longint'(v[0]) + v[2]) / 2 : (m == 2'h2) ? v[0] : v[1];
            vv = (vv * (4096 + longint'(vg[p]))) >>> 12;
            if (en[p]) s += vv * (c[p] >> 12) * (4096 + longint'(pg[p]));
        end
        q = (longint'(k) * (s >>> 24)) / ((d == 8'h00) ? 1 : d);
        return q[48:25];
    endfunction : model
    task automatic run(input logic [1:0] m);
        logic [2:0] en;
        logic [7:0] d;
        int k;
        en = 3'($urandom_range(1, 7));
        d = 8'($urandom_range(0, 4));
        k = $urandom_range(20, 60);
        bus(1'b1, tvae_pkg::ADR_MODE, {24'h000000, m, 6'h00});
        for (int p = 0; p < 3; p++) begin
            v[p] = 24'($urandom) & 24'hFFE000 | 24'h800000;
            c[p] = 24'($urandom) & 24'hFFF000 | 24'h800000;
            vg[p] = 12'($urandom);
            pg[p] = 12'($urandom);
            bus(1'b1, tvae_pkg::ADR_APPARENT_POWER_GAIN + 8'(4 * p), {20'h00000, pg[p]});
            bus(1'b1, tvae_pkg::ADR_VOLTAGE_CHANNEL_GAIN + 8'(4 * p), {20'h00000, vg[p]});
            rd(tvae_pkg::ADR_APPARENT_POWER_GAIN + 8'(4 * p), {20'h00000, pg[p]});
        end
        rms <= {v[0], v[1], v[2], c[0], c[1], c[2]};
        bus(1'b1, tvae_pkg::ADR_DIV, {24'h000000, d});
        rd(tvae_pkg::ADR_DIV, {24'h000000, d});
        rd(tvae_pkg::ADR_RCLR, 32'h00000000);
        // both writes take effect alike, so the terms stand exactly 12*k clocks
        bus(1'b1, tvae_pkg::ADR_MODE, {24'h000000, m, 3'h0, en});
        repeat (12 * k - 3) @(posedge clk);
        bus(1'b1, tvae_pkg::ADR_MODE, {24'h000000, m, 6'h00});
        repeat (150) @(posedge clk);
        rd(tvae_pkg::ADR_WIN, {8'h00, model(m, en, d, k)});
        rd(tvae_pkg::ADR_RCLR, {8'h00, model(m, en, d, k)});
        rd(tvae_pkg::ADR_WIN, 32'h00000000);
    endtask : run
    initial begin
        arst_n = 1'b0;
        rms = '0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h00000000;
        err_total = 0;
        check_count = 0;
        void'($urandom(66));
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(tvae_pkg::ADR_MODE, 32'h00000007);
        rd(tvae_pkg::ADR_IEN, 32'h00000000);
        rd(tvae_pkg::ADR_STAT, 32'h00000000);
        rd(8'h30, 32'h00000000);
        bus(1'b1, tvae_pkg::ADR_IEN, 32'h00000001);
        rd(tvae_pkg::ADR_IEN, 32'h00000001);
        bus(1'b1, tvae_pkg::ADR_WIN, 32'h00FFFFFF);
        rd(tvae_pkg::ADR_WIN, 32'h00000000);
        for (int r = 0; r < 8; r++) run(2'(r));
        conclude();
    end
endmodule : tvae_top_tb
